// [rtl/pfc_pkg.sv]
package pfc_pkg;

    // ****************************************************************
    // Register map, one byte-wide register per byte address.
    // ****************************************************************
    localparam logic [7:0] IDX_PORT_MUX      = 8'h2c;
    localparam logic [7:0] IDX_DEBOUNCE_TRIG = 8'h2d;
    localparam logic [7:0] IDX_TEST_A        = 8'h2e;
    localparam logic [7:0] IDX_TEST_B        = 8'h2f;
    localparam logic [7:0] IDX_FLOPPY_ACT    = 8'h30;
    localparam logic [7:0] IDX_FLOPPY_BASE_H = 8'h60;
    localparam logic [7:0] IDX_FLOPPY_BASE_L = 8'h61;
    localparam logic [7:0] IDX_FLOPPY_IRQ    = 8'h70;
    localparam int         ADDR_W            = 10;

    // ****************************************************************
    // Reset values and writable-bit masks.
    // ****************************************************************
    localparam logic [7:0] RST_PORT_MUX      = 8'h02;
    localparam logic [7:0] RST_DEBOUNCE_TRIG = 8'h00;
    localparam logic [7:0] RST_TEST          = 8'h00;
    localparam logic [7:0] RST_FLOPPY_ACT    = 8'h01;
    localparam logic [7:0] RST_FLOPPY_BASE_H = 8'h03;
    localparam logic [7:0] RST_FLOPPY_BASE_L = 8'hf0;
    localparam logic [7:0] RST_FLOPPY_IRQ    = 8'h06;
    localparam logic [7:0] MASK_PORT_MUX     = 8'hc7;
    localparam logic [7:0] MASK_DEBOUNCE     = 8'h77;
    localparam logic [7:0] MASK_FULL         = 8'hff;
    localparam logic [7:0] MASK_FLOPPY_ACT   = 8'h01;
    localparam logic [7:0] MASK_FLOPPY_IRQ   = 8'h0f;
    localparam logic [7:0] MASK_BASE_H       = 8'h0f;
    localparam logic [7:0] MASK_BASE_L       = 8'hf8;

    // ****************************************************************
    // Field positions.
    // ****************************************************************
    localparam int BIT_SECOND_PUSHPULL = 7;
    localparam int BIT_FIRST_PUSHPULL  = 6;
    localparam int BIT_THERMAL_EN      = 2;
    localparam int BIT_ROUTE_HI        = 1;
    localparam int BIT_ROUTE_LO        = 0;
    localparam int BIT_BYPASS_LO       = 4;
    localparam int BIT_TRIG_LO         = 0;
    localparam int BIT_FLOPPY_ACTIVE   = 0;
    localparam int PIN_IR_RX           = 4;
    localparam int PIN_IR_TX           = 5;

    // Pin routing codes of the first port group.
    localparam logic [1:0] ROUTE_RESERVED = 2'h0;
    localparam logic [1:0] ROUTE_INFRARED = 2'h1;
    localparam logic [1:0] ROUTE_GPIO     = 2'h2;
    localparam logic [1:0] ROUTE_SERIAL   = 2'h3;

    // ****************************************************************
    // Timing: debouncer settle time in microseconds at 10 MHz.
    // ****************************************************************
    localparam int CLK_MHZ        = 10;
    localparam int DEBOUNCE_US    = 100;
    localparam int DEBOUNCE_CYC   = DEBOUNCE_US * CLK_MHZ;
    localparam int DEB_CNT_W      = 10;
    localparam int NUM_INPUTS     = 3;

    localparam logic [11:0] BASE_MIN = 12'h100;
    localparam logic [11:0] BASE_MAX = 12'hff8;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pfc_pins_t;

endpackage

// [rtl/pfc_input_cond.sv]
`timescale 1ns/10ps
module pfc_input_cond
    import pfc_pkg::*;
(
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic pinIn,
    input  wire logic bypass,
    input  wire logic levelMode,
    output logic      cleanLevel,
    output logic      event_
);
    import pfc_pkg::*;

    logic [DEB_CNT_W-1:0] count;
    logic                 stable;
    logic                 prevClean;
    logic                 clean;

    // The input must hold a new value for the whole settle time before it is taken.
    always_ff @(posedge mclk) begin
        if (srst) begin
            stable <= 1'b0;
            count  <= '0;
        end else if (pinIn == stable) begin
            count <= '0;
        end else if (count == DEB_CNT_W'(DEBOUNCE_CYC - 1)) begin
            stable <= pinIn;
            count  <= '0;
        end else begin
            count <= count + 1'b1;
        end
    end

    assign clean = bypass ? pinIn : stable;

    always_ff @(posedge mclk) begin
        if (srst) begin
            prevClean  <= 1'b0;
            cleanLevel <= 1'b0;
            event_     <= 1'b0;
        end else begin
            prevClean  <= clean;
            cleanLevel <= clean;
            event_     <= levelMode ? clean : (clean & ~prevClean);
        end
    end

endmodule

// [rtl/pfc_config_regs.sv]
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
// Overview of operation
// - Bit 7 set makes second port group push-pull, clear gives open-drain.
// - Bit 6 set makes first port group push-pull, clear gives open-drain; serial routing, and pins 5..4 when reserved or infrared, ignore it.
// - Bit 2 enables thermal shutdown; kept in standby-powered domain.
// - Bits 1..0 route pins: reserved, infrared, all GPIO, serial port.
// - Multi-function register resets to 02h, standby-powered.
// - Bits 6..4 clear pass three inputs through debouncers, set bypass.
// - Bits 2..0 clear give edge trigger, set give level trigger.
// - Two test registers fully writable, reset 00h, leave untouched.
// - Floppy activate bit 0, resets 01h so controller starts active.
// - Floppy base from high and low bytes, 100h..FF8h, 8-byte aligned.
// - Floppy interrupt line picked by bits 3..0, reset 06h.
module pfc_config_regs
    import pfc_pkg::*;
(
    input  wire logic                      mclk,
    input  wire logic                      srst,
    input  wire logic                      standbyRst,
    input  wire logic [pfc_pkg::ADDR_W-1:0] avsAddress,
    input  wire logic                      avsRead,
    input  wire logic                      avsWrite,
    input  wire logic [31:0]               avsWritedata,
    input  wire logic [3:0]                avsByteenable,
    output logic [31:0]                    avsReaddata,
    output logic                           avsWaitrequest,
    output logic                           avsResponseError,
    input  wire logic [7:0]                firstPortOut,
    input  wire logic [7:0]                firstPortDrive,
    input  wire logic [7:0]                secondPortOut,
    input  wire logic [7:0]                secondPortDrive,
    input  wire logic                      serialTxd,
    input  wire logic                      serialOe,
    input  wire logic                      infraredTransmitIn,
    output pfc_pkg::pfc_pins_t             firstPortPins,
    output pfc_pkg::pfc_pins_t             secondPortPins,
    output logic                           infraredReceiveEn,
    output logic                           serialPortEn,
    output logic                           thermalShutdownEnable,
    input  wire logic [2:0]                inputPins,
    output logic [2:0]                     inputLevel,
    output logic [2:0]                     inputEvent,
    output logic [7:0]                     testModeA,
    output logic [7:0]                     testModeB,
    output logic                           floppyActive,
    output logic [11:0]                    floppyBase,
    output logic                           floppyBaseValid,
    output logic [3:0]                     floppyIrqLine
);
    import pfc_pkg::*;

    // ****************************************************************
    // Register storage.
    // ****************************************************************
    logic [7:0] portMux;
    logic [7:0] debounceTrig;
    logic [7:0] floppyAct;
    logic [7:0] baseHigh;
    logic [7:0] baseLow;
    logic [7:0] irqSel;
    logic       ackPhase;
    logic       access;
    logic       wrEn;
    logic [7:0] wrByte;
    logic [7:0] rdByte;
    logic       hit;

    // A byte-wide register sits on the byte lane given by the low address bits.
    function automatic logic [7:0] lane_byte(input logic [31:0] d, input logic [1:0] a);
        lane_byte = d[8*a +: 8];
    endfunction

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        logic [7:0] idx;
        idx = a[7:0];
        is_mapped = (a[ADDR_W-1:8] == '0) &&
            (idx == IDX_PORT_MUX || idx == IDX_DEBOUNCE_TRIG || idx == IDX_TEST_A ||
             idx == IDX_TEST_B || idx == IDX_FLOPPY_ACT || idx == IDX_FLOPPY_BASE_H ||
             idx == IDX_FLOPPY_BASE_L || idx == IDX_FLOPPY_IRQ);
    endfunction

    // ****************************************************************
    // Avalon slave: one wait cycle, then the answer.
    // ****************************************************************
    assign access         = avsRead | avsWrite;
    assign avsWaitrequest = access & ~ackPhase;
    assign hit            = is_mapped(avsAddress);
    assign wrByte         = lane_byte(avsWritedata, avsAddress[1:0]);
    assign wrEn           = avsWrite & ackPhase & hit & avsByteenable[avsAddress[1:0]];

    always_ff @(posedge mclk) begin
        if (srst) begin
            ackPhase <= 1'b0;
        end else begin
            ackPhase <= access & ~ackPhase;
        end
    end

    // The mux register lives on standby power, so only the standby reset loads it with 02h.
    always_ff @(posedge mclk) begin
        if (standbyRst) begin
            portMux <= RST_PORT_MUX;
        end else if (wrEn && avsAddress[7:0] == IDX_PORT_MUX) begin
            portMux <= wrByte & MASK_PORT_MUX;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            debounceTrig <= RST_DEBOUNCE_TRIG;
            testModeA    <= RST_TEST;
            testModeB    <= RST_TEST;
            floppyAct    <= RST_FLOPPY_ACT;
            baseHigh     <= RST_FLOPPY_BASE_H;
            baseLow      <= RST_FLOPPY_BASE_L;
            irqSel       <= RST_FLOPPY_IRQ;
        end else if (wrEn) begin
            case (avsAddress[7:0])
                IDX_DEBOUNCE_TRIG: debounceTrig <= wrByte & MASK_DEBOUNCE;
                IDX_TEST_A:        testModeA    <= wrByte & MASK_FULL;
                IDX_TEST_B:        testModeB    <= wrByte & MASK_FULL;
                IDX_FLOPPY_ACT:    floppyAct    <= wrByte & MASK_FLOPPY_ACT;
                IDX_FLOPPY_BASE_H: baseHigh     <= wrByte & MASK_BASE_H;
                IDX_FLOPPY_BASE_L: baseLow      <= wrByte & MASK_BASE_L;
                IDX_FLOPPY_IRQ:    irqSel       <= wrByte & MASK_FLOPPY_IRQ;
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        case (avsAddress[7:0])
            IDX_PORT_MUX:      rdByte = portMux;
            IDX_DEBOUNCE_TRIG: rdByte = debounceTrig;
            IDX_TEST_A:        rdByte = testModeA;
            IDX_TEST_B:        rdByte = testModeB;
            IDX_FLOPPY_ACT:    rdByte = floppyAct;
            IDX_FLOPPY_BASE_H: rdByte = baseHigh;
            IDX_FLOPPY_BASE_L: rdByte = baseLow;
            IDX_FLOPPY_IRQ:    rdByte = irqSel;
            default:           rdByte = 8'h00;
        endcase
    end

    // Read data is registered and stands on the cycle waitrequest drops.
    always_ff @(posedge mclk) begin
        if (srst) begin
            avsReaddata      <= 32'h0000_0000;
            avsResponseError <= 1'b0;
        end else if (access && !ackPhase) begin
            avsReaddata      <= (avsRead && hit) ? ({24'h000000, rdByte} << (8 * avsAddress[1:0]))
                                                 : 32'h0000_0000;
            avsResponseError <= ~hit;
        end
    end

    // ****************************************************************
    // Pin routing and output type.
    // ****************************************************************
    logic [1:0] route;
    assign route = portMux[BIT_ROUTE_HI:BIT_ROUTE_LO];

    always_comb begin
        firstPortPins.out = firstPortOut;
        // Open-drain drives only low, except the infrared and serial routings below; push-pull drives both levels.
        firstPortPins.oe  = portMux[BIT_FIRST_PUSHPULL] ? firstPortDrive
                                                        : (firstPortDrive & ~firstPortOut);
        infraredReceiveEn = 1'b0;
        serialPortEn      = 1'b0;
        case (route)
            ROUTE_RESERVED: begin
                firstPortPins.oe[PIN_IR_RX]  = 1'b0;
                firstPortPins.out[PIN_IR_TX] = 1'b0;
                firstPortPins.oe[PIN_IR_TX]  = 1'b1;
            end
            ROUTE_INFRARED: begin
                infraredReceiveEn             = 1'b1;
                firstPortPins.oe[PIN_IR_RX]  = 1'b0;
                firstPortPins.out[PIN_IR_TX] = infraredTransmitIn;
                firstPortPins.oe[PIN_IR_TX]  = 1'b1;
            end
            ROUTE_GPIO: begin
            end
            ROUTE_SERIAL: begin
                serialPortEn      = 1'b1;
                firstPortPins.out = {8{serialTxd}};
                firstPortPins.oe  = {8{serialOe}};
            end
            default: begin
            end
        endcase
    end

    always_comb begin
        secondPortPins.out = secondPortOut;
        secondPortPins.oe  = portMux[BIT_SECOND_PUSHPULL] ? secondPortDrive
                                                          : (secondPortDrive & ~secondPortOut);
    end

    assign thermalShutdownEnable = portMux[BIT_THERMAL_EN];

    // ****************************************************************
    // Input conditioning of the three general-purpose inputs.
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_INPUTS; gi++) begin : gInput
            pfc_input_cond uCond (
                .mclk       (mclk),
                .srst       (srst),
                .pinIn      (inputPins[gi]),
                .bypass     (debounceTrig[BIT_BYPASS_LO + gi]),
                .levelMode  (debounceTrig[BIT_TRIG_LO + gi]),
                .cleanLevel (inputLevel[gi]),
                .event_     (inputEvent[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // Floppy controller decode.
    // ****************************************************************
    assign floppyActive    = floppyAct[BIT_FLOPPY_ACTIVE];
    assign floppyBase      = {baseHigh[3:0], baseLow};
    assign floppyBaseValid = (floppyBase >= BASE_MIN) && (floppyBase <= BASE_MAX);
    assign floppyIrqLine   = irqSel[3:0];

endmodule

// [tb/pfc_config_regs_properties.sv]
`timescale 1ns/10ps
module pfc_config_regs_properties
    import pfc_pkg::*;
(
    input wire logic                        mclk,
    input wire logic                        srst,
    input wire logic                        standbyRst,
    input wire logic [pfc_pkg::ADDR_W-1:0]  avsAddress,
    input wire logic                        avsRead,
    input wire logic                        avsWrite,
    input wire logic [31:0]                 avsWritedata,
    input wire logic [3:0]                  avsByteenable,
    input wire logic [31:0]                 avsReaddata,
    input wire logic                        avsWaitrequest,
    input wire logic                        avsResponseError,
    input wire logic                        thermalShutdownEnable,
    input wire logic                        serialPortEn,
    input wire logic                        infraredReceiveEn,
    input wire logic [7:0]                  testModeA,
    input wire logic                        floppyActive,
    input wire logic [11:0]                 floppyBase,
    input wire logic                        floppyBaseValid,
    input wire logic [3:0]                  floppyIrqLine
);
    import pfc_pkg::*;
    // ****************************************************************
    // Helper logic.
    // ****************************************************************
    logic mapped;
    logic wrDone;
    assign mapped = (avsAddress[9:8] == 2'h0) && (avsAddress[7:0] inside {IDX_PORT_MUX,
        IDX_DEBOUNCE_TRIG, IDX_TEST_A, IDX_TEST_B, IDX_FLOPPY_ACT, IDX_FLOPPY_BASE_H,
        IDX_FLOPPY_BASE_L, IDX_FLOPPY_IRQ});
    assign wrDone = avsWrite && !avsWaitrequest;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst || standbyRst);
    // ****************************************************************
    // Properties.
    // ****************************************************************
    a_wait_state: assert property (
        $rose(avsRead || avsWrite) |-> avsWaitrequest ##1 !avsWaitrequest)
        else $error("waitrequest did not give exactly one wait state");
    a_unmapped_read: assert property (
        avsRead && !avsWaitrequest && !mapped |-> avsResponseError && avsReaddata == 32'h0)
        else $error("unmapped read did not return zero with error");
    a_thermal_write: assert property (
        wrDone && avsAddress == 10'h02c && avsByteenable[0] |=>
            thermalShutdownEnable == $past(avsWritedata[2]))
        else $error("thermal enable does not follow its bit");
    a_route_decode: assert property (
        wrDone && avsAddress == 10'h02c && avsByteenable[0] |=>
            serialPortEn == ($past(avsWritedata[1:0]) == 2'h3) &&
            infraredReceiveEn == ($past(avsWritedata[1:0]) == 2'h1))
        else $error("pin routing decode wrong");
    a_floppy_active: assert property (
        wrDone && avsAddress == 10'h030 && avsByteenable[0] |=>
            floppyActive == $past(avsWritedata[0]))
        else $error("floppy active does not follow its bit");
    a_irq_select: assert property (
        wrDone && avsAddress == 10'h070 && avsByteenable[0] |=>
            floppyIrqLine == $past(avsWritedata[3:0]))
        else $error("floppy interrupt line wrong");
    a_test_write: assert property (
        wrDone && avsAddress == 10'h02e && avsByteenable[2] |=>
            testModeA == $past(avsWritedata[23:16]))
        else $error("test register A not written");
    a_base_align: assert property (floppyBase[2:0] == 3'h0)
        else $error("floppy base not on an 8-byte boundary");
    a_base_range: assert property (
        floppyBaseValid == (floppyBase >= 12'h100 && floppyBase <= 12'hff8))
        else $error("floppy base valid flag wrong");
endmodule
bind pfc_config_regs pfc_config_regs_properties u_props (.mclk(mclk), .srst(srst),
    .standbyRst(standbyRst), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWritedata(avsWritedata), .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .avsResponseError(avsResponseError),
    .thermalShutdownEnable(thermalShutdownEnable), .serialPortEn(serialPortEn),
    .infraredReceiveEn(infraredReceiveEn), .testModeA(testModeA), .floppyActive(floppyActive),
    .floppyBase(floppyBase), .floppyBaseValid(floppyBaseValid), .floppyIrqLine(floppyIrqLine));

// [tb/tb.sv]
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_errors++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb;
    import pfc_pkg::*;
    logic             mclk, srst, standbyRst, avsRead, avsWrite, avsWaitrequest;
    logic             avsResponseError, serialTxd, serialOe, infraredTransmitIn, e;
    logic             infraredReceiveEn, serialPortEn, thermalShutdownEnable, floppyActive;
    logic             floppyBaseValid;
    logic [9:0]       avsAddress;
    logic [31:0]      avsWritedata, avsReaddata;
    logic [3:0]       avsByteenable, floppyIrqLine;
    logic [7:0]       firstPortOut, firstPortDrive, secondPortOut, secondPortDrive, q;
    logic [7:0]       testModeA, testModeB;
    logic [2:0]       inputPins, inputLevel, inputEvent;
    logic [11:0]      floppyBase;
    pfc_pins_t        firstPortPins, secondPortPins, fp;
    int               n_errors = 0;
    int               checked = 0;
    int               i, cnt;
    logic [7:0]       addrs [8] = '{8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h30, 8'h60, 8'h61, 8'h70};
    logic [7:0]       rsts  [8] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h01, 8'h03, 8'hf0, 8'h06};
    logic [7:0]       masks [8] = '{8'hc7, 8'h77, 8'hff, 8'hff, 8'h01, 8'h0f, 8'hf8, 8'h0f};

    pfc_config_regs u_pfc_config_regs (.mclk(mclk), .srst(srst), .standbyRst(standbyRst),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWritedata(avsWritedata), .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
        .avsWaitrequest(avsWaitrequest), .avsResponseError(avsResponseError),
        .firstPortOut(firstPortOut), .firstPortDrive(firstPortDrive),
        .secondPortOut(secondPortOut), .secondPortDrive(secondPortDrive),
        .serialTxd(serialTxd), .serialOe(serialOe), .infraredTransmitIn(infraredTransmitIn),
        .firstPortPins(firstPortPins), .secondPortPins(secondPortPins),
        .infraredReceiveEn(infraredReceiveEn), .serialPortEn(serialPortEn),
        .thermalShutdownEnable(thermalShutdownEnable), .inputPins(inputPins),
        .inputLevel(inputLevel), .inputEvent(inputEvent), .testModeA(testModeA),
        .testModeB(testModeB), .floppyActive(floppyActive), .floppyBase(floppyBase),
        .floppyBaseValid(floppyBaseValid), .floppyIrqLine(floppyIrqLine));

    assign fp = firstPortPins;

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic final_report;
        $display("Comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ****************************************************************
    // One Avalon access; the byte travels in the lane of address bits 1..0.
    // ****************************************************************
    task automatic acc(input logic [9:0] a, input logic w, input logic [7:0] d);
        int k;
        @(posedge mclk);
        avsAddress <= a;
        avsWrite <= w;
        avsRead <= !w;
        avsWritedata <= {4{d}};
        avsByteenable <= 4'h1 << a[1:0];
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (avsWaitrequest !== 1'b0 && k < 50);
        if (avsWaitrequest !== 1'b0) begin
            n_errors++;
            final_report();
        end
        q = avsReaddata[8*a[1:0] +: 8];
        e = avsResponseError;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        // The write lands on this edge, so callers look at outputs only after it settles.
        @(negedge mclk);
    endtask

    initial begin
        {srst, standbyRst} = 2'b11;
        {avsRead, avsWrite, avsAddress, avsWritedata, avsByteenable} = '0;
        {firstPortOut, firstPortDrive} = 16'h0fff;
        {secondPortOut, secondPortDrive} = 16'h0fff;
        // Infrared transmit idles high so that routing it differs from the held-low pin.
        {serialTxd, serialOe, infraredTransmitIn, inputPins} = 6'b001000;
        repeat (4) @(posedge mclk);
        {srst, standbyRst} <= 2'b00;
        for (i = 0; i < 8; i++) begin
            acc({2'h0, addrs[i]}, 1'b0, 8'h00);
            `CHK("reset value", rsts[i], q)
            `CHK("mapped error", 1'b0, e)
        end
        `CHK("first oe", 8'hf0, firstPortPins.oe)
        `CHK("second oe", 8'hf0, secondPortPins.oe)
        `CHK("floppy base", 12'h3f0, floppyBase)
        for (i = 0; i < 8; i++) begin
            acc({2'h0, addrs[i]}, 1'b1, 8'hff);
            acc({2'h0, addrs[i]}, 1'b0, 8'h00);
            `CHK("masked value", masks[i], q)
        end
        `CHK("second oe pp", 8'hff, secondPortPins.oe)
        `CHK("test b out", 8'hff, testModeB)
        `CHK("floppy base", 12'hff8, floppyBase)
        `CHK("floppy line", 4'hf, floppyIrqLine)
        for (i = 0; i < 8; i++) acc({2'h0, addrs[i]}, 1'b1, 8'h00);
        `CHK("floppy active", 1'b0, floppyActive)
        `CHK("base valid", 1'b0, floppyBaseValid)
        // Low byte matches a register, so only the upper address bits make it unmapped.
        acc(10'h12c, 1'b1, 8'h55);
        acc(10'h12c, 1'b0, 8'h00);
        `CHK("unmapped data", 8'h00, q)
        `CHK("unmapped error", 1'b1, e)
        for (i = 0; i < 4; i++) begin
            acc(10'h02c, 1'b1, {1'b0, i == 2, 3'h0, i[0], i[1:0]});
            `CHK("infrared", i == 1, infraredReceiveEn)
            `CHK("serial", i == 3, serialPortEn)
            `CHK("thermal", i[0], thermalShutdownEnable)
            if (i < 2) `CHK("ir pins", {2'b10, i == 1}, {fp.oe[5:4], fp.out[5]})
            if (i == 2) `CHK("first pp", 16'hff0f, {fp.oe, fp.out})
            if (i == 3) `CHK("serial pins", 16'h0000, fp)
        end
        acc(10'h02c, 1'b1, 8'h06);
        @(posedge mclk);
        srst <= 1'b1;
        @(posedge mclk);
        srst <= 1'b0;
        acc(10'h02c, 1'b0, 8'h00);
        `CHK("standby kept", 8'h06, q)
        acc(10'h030, 1'b0, 8'h00);
        `CHK("activate reset", 8'h01, q)
        acc(10'h02d, 1'b1, 8'h77);
        @(posedge mclk);
        inputPins <= 3'b101;
        repeat (4) @(negedge mclk);
        `CHK("level mode", 6'b101101, {inputLevel, inputEvent})
        acc(10'h02d, 1'b1, 8'h70);
        @(posedge mclk);
        inputPins <= 3'b000;
        repeat (4) @(posedge mclk);
        inputPins <= 3'b111;
        cnt = 0;
        repeat (6) begin
            @(negedge mclk);
            if (inputEvent === 3'b111) cnt++;
        end
        `CHK("edge pulse", 1, cnt)
        // The bypass still holds on the write edge, so give the level one more cycle.
        acc(10'h02d, 1'b1, 8'h00);
        @(negedge mclk);
        `CHK("debounce lag", 3'b000, inputLevel)
        repeat (1100) @(negedge mclk);
        `CHK("debounce rise", 3'b111, inputLevel)
        @(posedge mclk);
        inputPins <= 3'b000;
        repeat (500) @(negedge mclk);
        `CHK("debounce hold", 3'b111, inputLevel)
        repeat (600) @(negedge mclk);
        `CHK("debounce settle", 3'b000, inputLevel)
        final_report();
    end
endmodule
